// File: hw/slave_ack_pkg.sv
package slave_ack_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_LOCK = 8'h0C;
	// Control register fields
	localparam int CTRL_RX_PERMIT_BIT = 0;
	localparam int CTRL_TX_PERMIT_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// Slave status byte fields
	localparam int ST_TX_WRITTEN_BIT = 0;
	localparam int ST_RX_HELD_BIT = 1;
	localparam int ST_LOCKED_BIT = 2;
	localparam int ST_TX_READY_BIT = 4;
	localparam logic [1:0] ST_MODE = 2'h2;
	localparam logic ST_TX_WRITTEN_RESET = 1'b1;
	localparam int LOCK_ADDR_W = 12;
	localparam int CTRL_WRITE_BIT = 3;
	localparam logic ACK_BIT = 1'b0;
	localparam logic NACK_BIT = 1'b1;
	// Control codes
	localparam logic [3:0] CODE_STATUS = 4'h0;
	localparam logic [3:0] CODE_READ_LOCK = 4'h3;
	localparam logic [3:0] CODE_LOCK_LO = 4'h4;
	localparam logic [3:0] CODE_LOCK_HI = 4'h5;
	localparam logic [3:0] CODE_STATUS_UNLOCK = 4'h6;
	localparam logic [3:0] CODE_READ = 4'h7;
	localparam logic [3:0] CODE_CMD_LOCK = 4'hA;
	localparam logic [3:0] CODE_WRITE_LOCK = 4'hB;
	localparam logic [3:0] CODE_CMD = 4'hE;
	localparam logic [3:0] CODE_WRITE = 4'hF;

	typedef enum logic [1:0] {
		FLD_SLAVE = 2'h0,
		FLD_CTRL = 2'h1,
		FLD_LEN = 2'h2,
		FLD_DATA = 2'h3
	} field_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CTRL = 2'h1,
		ST_LEN = 2'h3,
		ST_DATA = 2'h2
	} sess_state_t;

	// One received field, reported by the field processing logic
	typedef struct packed {
		logic valid;
		field_kind_t kind;
		logic parity_ok;
		logic timing_err;
		logic bcast;
		logic addr_match;
		logic master_ack_n;
		logic [LOCK_ADDR_W-1:0] master_addr;
		logic [7:0] data;
	} field_evt_t;

	typedef struct packed {
		logic valid;
		logic nack;
		logic stop;
	} ack_out_t;
endpackage

// File: hw/bus_slave_ack_status_lock.sv
`timescale 1ns/10ps
// Behaviour
// - Slave field NACK and stop on address parity, timing error or no match.
// - Control field NACK and stop on control parity error.
// - Write code with receive permit clear: NACK, end individual transfer.
// - Data read 3H/7H with transmit permit clear: NACK control field.
// - Locked: codes 3,6,7,A,B,E,F from non-owner get NACK.
// - Lock address read 4H/5H while unlocked gets NACK.
// - Control NACK on timing error or undefined code.
// - Status request codes always ACK regardless of transmit permit.
// - Receive permit refuses individual only; broadcast continues, raises events.
// - Length field NACK and stop on parity or timing error.
// - Data byte NACK on parity, timing error, or full one-byte buffer.
// - Broadcast rejected byte: no resend, flag error, stop receiving.
// - Status byte reflects outcome of the latest communication.
// - Status bit 0: transmit data written; 1 after reset.
// - Status bit 1: received byte held; buffer one byte deep.
// - Status bit 4 mirrors the transmit permit flag.
// - Status bits 7:6 read fixed 10, mode 2.
// - Lock read 4H/5H returns 12-bit owner address in bytes.
// - Data read 3H/7H returns the slave data buffer.
// - Locked: refuse reception from all but owner, broadcast included.
// - Acknowledge bit 0 is ACK, 1 is NACK.
// - Locking code frame ends after ACKed length, bytes short: lock.
// - All bytes done under locking or unlock code: unlock.
module bus_slave_ack_status_lock
	import slave_ack_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire field_evt_t field_evt,
	input wire logic frame_end,
	input wire logic frame_all_done,
	output ack_out_t ack_out,
	output logic [7:0] tx_byte,
	output logic comm_error,
	output logic data_request_irq,
	output logic transfer_end_irq
);
	sess_state_t state_reg, state_next;
	logic [1:0] ctrl_reg;
	logic slave_rx_permit, slave_tx_permit;
	logic [7:0] byte_buffer_reg, rx_byte_reg;
	logic tx_written_reg, rx_held_reg, locked_reg;
	logic [LOCK_ADDR_W-1:0] lock_addr_reg, master_reg;
	logic [3:0] code_reg;
	logic bcast_reg, len_acked_reg, byte_idx_reg;
	logic [7:0] status_byte;
	logic lock_other, code_defined, code_guarded, code_lock;
	logic nack_now, stop_now, err_now, rx_take, rd_ack;
	logic ev_slave, ev_ctrl, ev_len, ev_data;
	logic [3:0] code_in;
	logic wr_pend_reg;
	logic [7:0] waddr_reg;
	logic [31:0] hrdata_reg;
	ack_out_t ack_reg;
	logic [7:0] tx_byte_reg;
	logic comm_err_reg, dreq_reg, tend_reg;
	logic ahb_req, sw_data_rd, sw_data_wr;

	assign slave_rx_permit = ctrl_reg[CTRL_RX_PERMIT_BIT];
	assign slave_tx_permit = ctrl_reg[CTRL_TX_PERMIT_BIT];
	assign status_byte = {ST_MODE, 1'b0, slave_tx_permit, 1'b0,
		locked_reg, rx_held_reg, tx_written_reg};

	// AHB-Lite slave, zero wait states
	assign ahb_req = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign sw_data_rd = ahb_req & ~hwrite & (haddr == OFS_DATA);
	assign sw_data_wr = wr_pend_reg & (waddr_reg == OFS_DATA);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			waddr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= ahb_req & hwrite;
			if (ahb_req) begin
				waddr_reg <= haddr;
			end
		end
	end

	// Read data is captured at the address phase so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (ahb_req && !hwrite) begin
			case (haddr)
			OFS_CTRL: hrdata_reg <= {30'h00000000, ctrl_reg};
			OFS_DATA: hrdata_reg <= {24'h000000, rx_byte_reg};
			OFS_STATUS: hrdata_reg <= {24'h000000, status_byte};
			OFS_LOCK: hrdata_reg <= {20'h00000, lock_addr_reg};
			default: hrdata_reg <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_pend_reg && waddr_reg == OFS_CTRL) begin
			ctrl_reg <= hwdata[1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			byte_buffer_reg <= 8'h00;
		end else if (sw_data_wr) begin
			byte_buffer_reg <= hwdata[7:0];
		end
	end

	// Field classification
	assign code_in = field_evt.data[3:0];
	assign ev_slave = field_evt.valid & (field_evt.kind == FLD_SLAVE)
		& (state_reg == ST_IDLE);
	assign ev_ctrl = field_evt.valid & (field_evt.kind == FLD_CTRL)
		& (state_reg == ST_CTRL);
	assign ev_len = field_evt.valid & (field_evt.kind == FLD_LEN)
		& (state_reg == ST_LEN);
	assign ev_data = field_evt.valid & (field_evt.kind == FLD_DATA)
		& (state_reg == ST_DATA);
	assign lock_other = locked_reg & (master_reg != lock_addr_reg);

	always_comb begin
		case (code_in)
		CODE_STATUS, CODE_READ_LOCK, CODE_LOCK_LO, CODE_LOCK_HI,
		CODE_STATUS_UNLOCK, CODE_READ, CODE_CMD_LOCK, CODE_WRITE_LOCK,
		CODE_CMD, CODE_WRITE: code_defined = 1'b1;
		default: code_defined = 1'b0;
		endcase
	end

	always_comb begin
		case (code_in)
		CODE_READ_LOCK, CODE_STATUS_UNLOCK, CODE_READ, CODE_CMD_LOCK,
		CODE_WRITE_LOCK, CODE_CMD, CODE_WRITE: code_guarded = 1'b1;
		default: code_guarded = 1'b0;
		endcase
	end

	assign code_lock = (code_reg == CODE_READ_LOCK)
		| (code_reg == CODE_CMD_LOCK) | (code_reg == CODE_WRITE_LOCK);

	// Acknowledge decision per field
	always_comb begin
		nack_now = 1'b0;
		stop_now = 1'b0;
		err_now = 1'b0;
		rx_take = 1'b0;
		rd_ack = 1'b0;
		state_next = state_reg;
		if (ev_slave) begin
			nack_now = ~field_evt.parity_ok | field_evt.timing_err
				| ~field_evt.addr_match;
			if (locked_reg && field_evt.master_addr != lock_addr_reg) begin
				nack_now = 1'b1;
			end
			stop_now = nack_now;
			state_next = nack_now ? ST_IDLE : ST_CTRL;
		end else if (ev_ctrl) begin
			nack_now = ~field_evt.parity_ok
				| field_evt.timing_err | ~code_defined
				| (lock_other & code_guarded)
				| (~locked_reg & ((code_in == CODE_LOCK_LO)
				| (code_in == CODE_LOCK_HI)));
			// Broadcast keeps running with reception disabled
			if (code_in[CTRL_WRITE_BIT] && !slave_rx_permit
				&& !bcast_reg) begin
				nack_now = 1'b1;
			end
			// Status codes never consult the transmit permit
			if ((code_in == CODE_READ_LOCK || code_in == CODE_READ)
				&& !slave_tx_permit) begin
				nack_now = 1'b1;
			end
			stop_now = nack_now;
			state_next = nack_now ? ST_IDLE : ST_LEN;
		end else if (ev_len) begin
			stop_now = ~field_evt.parity_ok | field_evt.timing_err;
			nack_now = stop_now | bcast_reg;
			state_next = stop_now ? ST_IDLE : ST_DATA;
		end else if (ev_data && code_reg[CTRL_WRITE_BIT]) begin
			nack_now = ~field_evt.parity_ok | field_evt.timing_err
				| rx_held_reg | lock_other;
			rx_take = ~nack_now;
			if (bcast_reg) begin
				err_now = nack_now;
				stop_now = nack_now;
				nack_now = 1'b1;
			end else begin
				stop_now = field_evt.timing_err;
			end
			state_next = stop_now ? ST_IDLE : ST_DATA;
		end else if (ev_data) begin
			rd_ack = ~field_evt.master_ack_n & ~field_evt.timing_err;
			stop_now = field_evt.timing_err;
			state_next = stop_now ? ST_IDLE : ST_DATA;
		end
		if (frame_end) begin
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Answer to the link; read-data fields carry no answer from us
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_reg <= '0;
			comm_err_reg <= 1'b0;
			dreq_reg <= 1'b0;
			tend_reg <= 1'b0;
		end else begin
			ack_reg.valid <= ev_slave | ev_ctrl | ev_len
				| (ev_data & code_reg[CTRL_WRITE_BIT]);
			ack_reg.nack <= nack_now ? NACK_BIT : ACK_BIT;
			ack_reg.stop <= stop_now;
			comm_err_reg <= err_now;
			dreq_reg <= rx_take;
			tend_reg <= frame_end & (state_reg != ST_IDLE);
		end
	end
	assign ack_out = ack_reg;
	assign comm_error = comm_err_reg;
	assign data_request_irq = dreq_reg;
	assign transfer_end_irq = tend_reg;

	// Session context
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_reg <= '0;
			code_reg <= CODE_STATUS;
			bcast_reg <= 1'b0;
			len_acked_reg <= 1'b0;
			byte_idx_reg <= 1'b0;
		end else begin
			if (ev_slave) begin
				master_reg <= field_evt.master_addr;
				bcast_reg <= field_evt.bcast;
				len_acked_reg <= 1'b0;
			end
			if (ev_ctrl) begin
				code_reg <= code_in;
				byte_idx_reg <= 1'b0;
			end
			if (ev_len && !stop_now) begin
				len_acked_reg <= 1'b1;
			end
			if (rd_ack) begin
				byte_idx_reg <= ~byte_idx_reg;
			end
		end
	end

	// Byte offered on master reads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_byte_reg <= 8'h00;
		end else if ((ev_ctrl && !nack_now) || rd_ack) begin
			case (ev_ctrl ? code_in : code_reg)
			CODE_READ_LOCK, CODE_READ: tx_byte_reg <= byte_buffer_reg;
			CODE_LOCK_LO, CODE_LOCK_HI: tx_byte_reg <= (ev_ctrl
				|| byte_idx_reg) ? lock_addr_reg[7:0]
				: {4'h0, lock_addr_reg[11:8]};
			default: tx_byte_reg <= status_byte;
			endcase
		end
	end
	assign tx_byte = tx_byte_reg;

	// Software write set wins over a master read clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_written_reg <= ST_TX_WRITTEN_RESET;
		end else if (sw_data_wr) begin
			tx_written_reg <= 1'b1;
		end else if (rd_ack && (code_reg == CODE_READ_LOCK
			|| code_reg == CODE_READ)) begin
			tx_written_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_held_reg <= 1'b0;
			rx_byte_reg <= 8'h00;
		end else if (rx_take) begin
			rx_held_reg <= 1'b1;
			rx_byte_reg <= field_evt.data;
		end else if (sw_data_rd) begin
			rx_held_reg <= 1'b0;
		end
	end

	// Lock only in individual frames
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			locked_reg <= 1'b0;
			lock_addr_reg <= '0;
		end else if (frame_end && !bcast_reg && len_acked_reg
			&& state_reg == ST_DATA) begin
			if (frame_all_done && (code_lock
				|| code_reg == CODE_STATUS_UNLOCK)) begin
				locked_reg <= 1'b0;
			end else if (!frame_all_done && code_lock && !lock_other) begin
				locked_reg <= 1'b1;
				lock_addr_reg <= master_reg;
			end
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_ctrl_ok_code(logic [3:0] c);
		ev_ctrl && field_evt.parity_ok && !field_evt.timing_err
			&& code_in == c;
	endsequence
	sequence s_nack_stop;
		ack_out.valid && ack_out.nack == NACK_BIT && ack_out.stop;
	endsequence

	a_slave_field_nack: assert property (ev_slave && (!field_evt.parity_ok
		|| !field_evt.addr_match) |=> s_nack_stop)
		else $error("slave field not refused");
	a_ctrl_parity_nack: assert property (ev_ctrl && !field_evt.parity_ok
		|=> s_nack_stop ##1 state_reg == ST_IDLE)
		else $error("control parity error not refused");
	a_ctrl_write_off: assert property (ev_ctrl && code_in[CTRL_WRITE_BIT]
		&& !slave_rx_permit && !bcast_reg |=> s_nack_stop)
		else $error("write accepted with reception off");
	a_ctrl_read_off: assert property (s_ctrl_ok_code(CODE_READ)
		and (!slave_tx_permit) |=> s_nack_stop)
		else $error("data read accepted with transmission off");
	a_lock_read_idle: assert property (s_ctrl_ok_code(CODE_LOCK_LO)
		and (!locked_reg) |=> ack_out.nack)
		else $error("lock read accepted while unlocked");
	a_status_ack: assert property (s_ctrl_ok_code(CODE_STATUS)
		|=> ack_out.valid && ack_out.nack == ACK_BIT)
		else $error("status request refused");
	a_len_nack: assert property (ev_len && (field_evt.timing_err
		|| !field_evt.parity_ok) |=> s_nack_stop)
		else $error("length field error not refused");
	a_data_full: assert property (ev_data && code_reg[CTRL_WRITE_BIT]
		&& rx_held_reg |=> ack_out.nack ##0 $stable(rx_byte_reg))
		else $error("byte taken into a full buffer");
	a_bcast_error: assert property (ev_data && bcast_reg
		&& code_reg[CTRL_WRITE_BIT] && (!field_evt.parity_ok
		|| rx_held_reg)
		|=> comm_error && ack_out.stop ##1 state_reg == ST_IDLE)
		else $error("broadcast rejection not flagged");
	a_tx_ready_mirror: assert property (ahb_req && !hwrite
		&& haddr == OFS_STATUS
		|=> hrdata[ST_TX_READY_BIT] == $past(slave_tx_permit))
		else $error("status transmit ready out of step");
	a_lock_set: assert property (frame_end && state_reg == ST_DATA
		&& !bcast_reg && len_acked_reg && code_lock && !frame_all_done
		&& !locked_reg |=> locked_reg && lock_addr_reg == $past(master_reg))
		else $error("frame cut short did not lock");
endmodule

// File: sim/remote_master.sv
`timescale 1ns/10ps
module remote_master
	import slave_ack_pkg::*;
(
	input wire logic hclk,
	input wire ack_out_t ack_out,
	output field_evt_t field_evt,
	output logic frame_end,
	output logic frame_all_done
);
	initial begin
		field_evt = '0;
		frame_end = 1'b0;
		frame_all_done = 1'b0;
	end

	// Idle payload is inverted so stale data never looks valid
	task automatic send(input field_evt_t e, output ack_out_t a);
		@(posedge hclk);
		field_evt <= e;
		@(posedge hclk);
		field_evt.valid <= 1'b0;
		field_evt.data <= ~e.data;
		#1;
		a = ack_out;
	endtask

	// Individual only; broadcast bytes go through send once
	task automatic put_byte(input field_evt_t e, input int tries,
		output ack_out_t a);
		do begin
			send(e, a);
			tries--;
		end while (a.nack === NACK_BIT && a.stop !== 1'b1 && tries > 0);
	endtask

	task automatic end_frame(input logic all_done);
		@(posedge hclk);
		frame_end <= 1'b1;
		frame_all_done <= all_done;
		@(posedge hclk);
		frame_end <= 1'b0;
		frame_all_done <= ~all_done;
		#1;
	endtask
endmodule

// File: sim/bus_slave_ack_status_lock_tb.sv
`timescale 1ns/10ps
module bus_slave_ack_status_lock_tb;
	import slave_ack_pkg::*;
	localparam logic [4:0] GOOD = 5'h12;
	localparam logic [4:0] BADP = 5'h02;
	localparam logic [4:0] TERR = 5'h1A;
	localparam logic [4:0] NOM = 5'h10;
	localparam logic [4:0] BC = 5'h16;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [7:0] haddr, tx_byte;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	field_evt_t field_evt;
	ack_out_t ack_out, a;
	logic frame_end, frame_all_done;
	logic comm_error, data_request_irq, transfer_end_irq;
	logic [11:0] who;
	logic [15:0] nack_map;
	logic [4:0] bad [3];
	int failures;
	int compares;

	bus_slave_ack_status_lock i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .field_evt(field_evt),
		.frame_end(frame_end), .frame_all_done(frame_all_done),
		.ack_out(ack_out), .tx_byte(tx_byte), .comm_error(comm_error),
		.data_request_irq(data_request_irq),
		.transfer_end_irq(transfer_end_irq));

	remote_master i_master (.hclk(hclk), .ack_out(ack_out),
		.field_evt(field_evt), .frame_end(frame_end),
		.frame_all_done(frame_all_done));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic check(input string n, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
	endtask

	task automatic ahb(input logic wr, input logic [7:0] ad,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask

	function automatic field_evt_t fe(input field_kind_t k,
		input logic [7:0] d, input logic [4:0] f);
		fe = '{1'b1, k, f[4], f[3], f[2], f[1], f[0], who, d};
	endfunction

	task automatic fld(input field_kind_t k, input logic [7:0] d,
		input logic [4:0] f);
		i_master.send(fe(k, d, f), a);
	endtask

	task automatic fa(input field_kind_t k, input logic [7:0] d,
		input logic [4:0] f, input logic [2:0] e);
		fld(k, d, f);
		check("ack", a, e);
	endtask

	task automatic begin_frame(input logic [3:0] c);
		fa(FLD_SLAVE, 8'h0, GOOD, 3'b100);
		fa(FLD_CTRL, {4'h0, c}, GOOD, 3'b100);
	endtask

	initial begin
		#200000;
		failures++;
		summarize();
	end

	initial begin
		failures = 0;
		compares = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		who = 12'h123;
		bad = '{BADP, TERR, NOM};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("status", rd, 32'h81);
		ahb(1'b0, 8'h10, 32'h0);
		check("unmapped", rd, 32'h0);
		for (int i = 0; i < 3; i++)
			fa(FLD_SLAVE, 8'h0, bad[i], 3'b111);
		for (int p = 0; p < 2; p++) begin
			ahb(1'b1, OFS_CTRL, p ? 32'h3 : 32'h0);
			ahb(1'b0, OFS_STATUS, 32'h0);
			check("tx ready", rd[4], p[0]);
			nack_map = p ? 16'h3336 : 16'hFFBE;
			for (int c = 0; c < 16; c++) begin
				fa(FLD_SLAVE, 8'h0, GOOD, 3'b100);
				fa(FLD_CTRL, 8'(c), GOOD, {1'b1, {2{nack_map[c]}}});
				i_master.end_frame(1'b0);
				check("end irq", transfer_end_irq, !nack_map[c]);
			end
		end
		for (int i = 0; i < 2; i++) begin
			fa(FLD_SLAVE, 8'h0, GOOD, 3'b100);
			fa(FLD_CTRL, CODE_WRITE, i ? TERR : BADP, 3'b111);
		end
		begin_frame(CODE_WRITE);
		fa(FLD_LEN, 8'h2, GOOD, 3'b100);
		fa(FLD_DATA, 8'h5A, BADP, 3'b110);
		fa(FLD_DATA, 8'h5A, GOOD, 3'b100);
		check("rx irq", data_request_irq, 1'b1);
		i_master.put_byte(fe(FLD_DATA, 8'hA5, GOOD), 3, a);
		check("full", a, 3'b110);
		i_master.end_frame(1'b0);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("rx held", rd[1], 1'b1);
		ahb(1'b0, OFS_DATA, 32'h0);
		check("rx byte", rd, 32'h5A);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("rx held", rd[1], 1'b0);
		for (int i = 0; i < 2; i++) begin
			begin_frame(CODE_WRITE);
			fa(FLD_LEN, 8'h1, i ? GOOD : BADP, i ? 3'b100 : 3'b111);
			if (i)
				fa(FLD_DATA, 8'h11, TERR, 3'b111);
		end
		// Master read drains the transmit byte, then software refills it
		ahb(1'b1, OFS_DATA, 32'hC3);
		begin_frame(CODE_READ);
		fld(FLD_LEN, 8'h1, GOOD);
		check("tx byte", tx_byte, 8'hC3);
		fld(FLD_DATA, 8'h0, GOOD);
		i_master.end_frame(1'b1);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("tx written", rd[0], 1'b0);
		ahb(1'b1, OFS_DATA, 32'h44);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("tx written", rd[0], 1'b1);
		// Short locking frame leaves the unit owned
		begin_frame(CODE_WRITE_LOCK);
		fa(FLD_LEN, 8'h2, GOOD, 3'b100);
		fa(FLD_DATA, 8'h77, GOOD, 3'b100);
		i_master.end_frame(1'b0);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("locked", rd[2], 1'b1);
		ahb(1'b0, OFS_LOCK, 32'h0);
		check("owner", rd, 32'h123);
		ahb(1'b0, OFS_DATA, 32'h0);
		who = 12'h456;
		fa(FLD_SLAVE, 8'h0, GOOD, 3'b111);
		fa(FLD_SLAVE, 8'h0, BC, 3'b111);
		who = 12'h123;
		begin_frame(CODE_LOCK_HI);
		fld(FLD_LEN, 8'h2, GOOD);
		check("lock lo", tx_byte, 8'h23);
		fld(FLD_DATA, 8'h0, 5'h13);
		check("lock held", tx_byte, 8'h23);
		fld(FLD_DATA, 8'h0, GOOD);
		check("lock hi", tx_byte, 8'h01);
		i_master.end_frame(1'b1);
		begin_frame(CODE_WRITE_LOCK);
		fa(FLD_LEN, 8'h1, GOOD, 3'b100);
		fa(FLD_DATA, 8'h78, GOOD, 3'b100);
		i_master.end_frame(1'b1);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("locked", rd[2], 1'b0);
		ahb(1'b0, OFS_DATA, 32'h0);
		ahb(1'b1, OFS_CTRL, 32'h0);
		fld(FLD_SLAVE, 8'h0, BC);
		fld(FLD_CTRL, CODE_WRITE, GOOD);
		check("bc stop", a.stop, 1'b0);
		fa(FLD_LEN, 8'h2, GOOD, 3'b110);
		fa(FLD_DATA, 8'h3C, GOOD, 3'b110);
		check("bc irq", data_request_irq, 1'b1);
		fld(FLD_DATA, 8'h3D, GOOD);
		check("bc err", comm_error, 1'b1);
		i_master.end_frame(1'b0);
		ahb(1'b0, OFS_DATA, 32'h0);
		check("bc byte", rd, 32'h3C);
		summarize();
	end
endmodule
